//--- emsi_pkg.sv
// Overview of operation
// [RULE_01] One 14-bit address bus shared by program, data and boot accesses.
// [RULE_02] 24-bit two-way data bus; boot reads input only, top two lines address; code puts the boot address on the address bus only.
// [RULE_03] Program space select low during every external program access.
// [RULE_04] Write strobe pulses on writes, read strobe on reads.
// [RULE_05] Program writes take low eight bits from the extension register.
// [RULE_06] Program reads put upper sixteen bits out, low eight into extension register.
// [RULE_07] Program wait states zero to seven, seven after reset.
// [RULE_08] Reset empties stack pointers, masks interrupts, clears mode status.
// [RULE_09] Boot runs on release only with no bus request and map select low.
// [RULE_10] After reset handling the first fetch is internal address zero; code fetches address zero in both maps, external with map select high.
// [RULE_11] Power-up reset held low at least 2000 input clock cycles.
// [RULE_12] Later resets keep the clock running; only minimum pulse width needed; code holds the output clock low while reset is asserted.
// [RULE_13] Output clock is synchronised to instruction cycles.
// [RULE_14] Serial port one pins double as two interrupts, flag in and flag out.
// [RULE_15] Map select level chooses one of two program memory maps.
// [RULE_16] Map low: internal RAM 512 words at zero, external from 0x0800; code sends every program address above 0x01ff external.
// [RULE_17] Map high: external from zero, internal at 0x3800-0x39ff, no boot.
// [RULE_18] Bus request while idle: next cycle float bus, grant, halt.
// [RULE_19] At most one space select; strobes idle without an access.
package emsi_pkg;
	localparam int          ADDR_W          = 14;
	localparam int          DATA_W          = 24;
	localparam int          WORD_W          = 16;
	localparam int          EXT_W           = 8;
	localparam logic [2:0]  PM_WAIT_RST     = 3'h7;
	localparam logic [2:0]  BOOT_WAIT_RST   = 3'h3;
	localparam logic [2:0]  PAGE_RST        = 3'h0;
	localparam logic [13:0] EXT_BASE_MAP0   = 14'h0800;
	localparam logic [13:0] INT_BASE_MAP1   = 14'h3800;
	localparam logic [13:0] INT_LAST_MAP1   = 14'h39ff;
	localparam logic [13:0] INT_LAST_MAP0   = 14'h01ff;
	localparam logic [13:0] FIRST_FETCH     = 14'h0000;
	localparam logic [10:0] BOOT_BYTES      = 11'h7ff;
	localparam logic [6:0]  MODE_RST        = 7'h00;
	localparam logic [2:0]  STACK_EMPTY     = 3'h0;
	localparam logic [3:0]  IMASK_RST       = 4'h0;

	typedef enum logic [1:0] {SP_PROG, SP_DATA, SP_BOOT} space_t;

	function automatic logic is_internal(input logic map_hi, input logic [13:0] a);
		is_internal = map_hi ? (a >= INT_BASE_MAP1 && a <= INT_LAST_MAP1) : (a <= INT_LAST_MAP0);
	endfunction
endpackage

//--- emsi_req_if.sv
`timescale 1ns/100ps
`default_nettype none
interface emsi_req_if;
	logic        valid;
	logic        write;
	logic [1:0]  space;
	logic [13:0] addr;
	logic [23:0] wdata;
	logic [2:0]  waits;
	logic        done;
	logic [23:0] rdata;
	modport master (output valid, write, space, addr, wdata, waits, input done, rdata);
	modport slave  (input valid, write, space, addr, wdata, waits, output done, rdata);
endinterface
`default_nettype wire

//--- emsi_cycle.sv
`timescale 1ns/100ps
`default_nettype none
module emsi_cycle
	import emsi_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Request
	emsi_req_if.slave        req,
	input  wire logic        granted,
	// Pins
	output logic [13:0]      addr_out,
	output logic [23:0]      data_out,
	output logic             data_oe_n,
	input  wire logic [23:0] data_in,
	output logic             program_space_select_n,
	output logic             data_space_select_n,
	output logic             boot_space_select_n,
	output logic             read_strobe_n,
	output logic             write_strobe_n,
	output logic             busy
);
	typedef struct packed {
		logic        act;
		logic [2:0]  cnt;
		logic [13:0] a;
		logic [23:0] d;
		logic        wr;
		logic [1:0]  sp;
		logic [23:0] rd;
		logic        done;
	} st_t;
	st_t s_q, s_d;

	always_comb
	begin
		s_d = s_q;
		s_d.done = 1'b0;
		if (!s_q.act)
		begin
			if (req.valid && !granted && !s_q.done)
			begin
				s_d.act = 1'b1;
				s_d.cnt = req.waits; // [RULE_07]
				s_d.a = req.addr; // [RULE_01]
				s_d.d = req.wdata;
				s_d.wr = req.write && (req.space != SP_BOOT); // [RULE_02]
				s_d.sp = req.space;
			end
		end
		else if (s_q.cnt == 3'h0)
		begin
			s_d.act = 1'b0;
			s_d.done = 1'b1;
			s_d.rd = data_in;
		end
		else
			s_d.cnt = s_q.cnt - 3'h1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign addr_out               = s_q.a;
	assign data_out               = s_q.d;
	assign data_oe_n              = !(s_q.act && s_q.wr); // [RULE_02]
	assign program_space_select_n = !(s_q.act && s_q.sp == SP_PROG); // [RULE_03] [RULE_19]
	assign data_space_select_n    = !(s_q.act && s_q.sp == SP_DATA); // [RULE_19]
	assign boot_space_select_n    = !(s_q.act && s_q.sp == SP_BOOT);
	assign read_strobe_n          = !(s_q.act && !s_q.wr); // [RULE_04] [RULE_19]
	assign write_strobe_n         = !(s_q.act && s_q.wr); // [RULE_04]
	assign busy                   = s_q.act;
	assign req.done               = s_q.done;
	assign req.rdata              = s_q.rd;
endmodule
`default_nettype wire

//--- emsi_boot_ram.sv
`timescale 1ns/100ps
`default_nettype none
module emsi_boot_ram #(
	parameter int DEPTH = 512,
	parameter int WIDTH = 24
) (
	// Clock
	input  wire logic                     pclk,
	// Port
	input  wire logic                     we,
	input  wire logic [$clog2(DEPTH)-1:0] waddr,
	input  wire logic [WIDTH-1:0]         wdata,
	input  wire logic [$clog2(DEPTH)-1:0] raddr,
	output logic [WIDTH-1:0]              rdata
);
	if (DEPTH < 2 || WIDTH < 1)
		$error("bad memory size");
	logic [WIDTH-1:0] mem [DEPTH];
	always_ff @(posedge pclk)
	begin
		if (we)
			mem[waddr] <= wdata;
		rdata <= mem[raddr];
	end
endmodule
`default_nettype wire

//--- ext_memory_system_interface.sv
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module ext_memory_system_interface
	import emsi_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Memory pins
	output logic [13:0]      addr_out,
	output logic             addr_oe_n,
	output logic [23:0]      data_out,
	output logic             data_oe_n,
	input  wire logic [23:0] data_in,
	output logic             program_space_select_n,
	output logic             data_space_select_n,
	output logic             boot_space_select_n,
	output logic             read_strobe_n,
	output logic             write_strobe_n,
	output logic             ctrl_oe_n,
	// Bus arbitration and map
	input  wire logic        bus_request_n,
	output logic             bus_grant_n,
	input  wire logic        memory_map_select,
	// Clock out and serial port one alternate pins
	output logic             output_clock,
	input  wire logic        port_one_receive_frame_sync,
	input  wire logic        port_one_transmit_frame_sync,
	input  wire logic        port_one_receive_data,
	output logic             port_one_transmit_data,
	output logic             ext_interrupt_zero_n,
	output logic             ext_interrupt_one_n,
	output logic             flag_input_pin,
	// Core status
	output logic             halted,
	output logic [13:0]      fetch_addr,
	output logic             fetch_valid
);
	// Register map
	localparam logic [11:0] R_CTRL  = 12'h000;
	localparam logic [11:0] R_ACC   = 12'h004;
	localparam logic [11:0] R_DATA  = 12'h008;
	localparam logic [11:0] R_PX    = 12'h00c;
	localparam logic [11:0] R_STAT  = 12'h010;
	localparam logic [11:0] R_MODE  = 12'h014;

	typedef enum logic [2:0] {ST_RESET, ST_BOOT_REQ, ST_BOOT_WAIT, ST_RUN, ST_ACC_WAIT} fsm_t;

	typedef struct packed {
		fsm_t        fsm;
		logic        map_hi;
		logic [2:0]  pm_wait;
		logic [2:0]  dm_wait;
		logic [2:0]  boot_wait;
		logic [2:0]  page;
		logic        sport_alt;
		logic        flag_out;
		logic [7:0]  px;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic [6:0]  mode;
		logic [3:0]  imask;
		logic [2:0]  stack_ptr;
		logic        grant;
		logic        clk_div;
		logic [10:0] boot_idx;
		logic [1:0]  boot_byte;
		logic [15:0] boot_acc;
		logic        boot_we;
		logic        force_boot;
		logic        req_valid;
		logic        req_write;
		logic [1:0]  req_space;
		logic [13:0] req_addr;
		logic        acc_err;
		logic [13:0] fetch;
		logic        fetch_v;
		logic [31:0] prdata;
	} st_t;
	st_t s_q, s_d;

	emsi_req_if rq ();
	logic       busy;
	logic [23:0] ram_rdata;

	function automatic logic [2:0] waits_for(input logic [1:0] sp, input st_t s);
		unique case (sp)
			SP_PROG: waits_for = s.pm_wait; // [RULE_07]
			SP_DATA: waits_for = s.dm_wait;
			default: waits_for = s.boot_wait;
		endcase
	endfunction

	assign rq.valid = s_q.req_valid;
	assign rq.write = s_q.req_write;
	assign rq.space = s_q.req_space;
	assign rq.addr  = s_q.req_addr;
	assign rq.wdata = (s_q.req_space == SP_PROG) ? {s_q.wdata, s_q.px} : {s_q.wdata, 8'h00}; // [RULE_05]
	assign rq.waits = waits_for(s_q.req_space, s_q);

	emsi_cycle u_cycle (
		.pclk                   (pclk),
		.presetn                (presetn),
		.req                    (rq.slave),
		.granted                (s_q.grant),
		.addr_out               (addr_out),
		.data_out               (data_out),
		.data_oe_n              (data_oe_n),
		.data_in                (data_in),
		.program_space_select_n (program_space_select_n),
		.data_space_select_n    (data_space_select_n),
		.boot_space_select_n    (boot_space_select_n),
		.read_strobe_n          (read_strobe_n),
		.write_strobe_n         (write_strobe_n),
		.busy                   (busy)
	);

	emsi_boot_ram #(.DEPTH(512), .WIDTH(24)) u_ram (
		.pclk  (pclk),
		.we    (s_q.boot_we),
		.waddr (s_q.boot_idx[8:0] - 9'h1),
		.wdata ({s_q.boot_acc, rq.rdata[15:8]}),
		.raddr (9'h000),
		.rdata (ram_rdata)
	);

	always_comb
	begin
		s_d = s_q;
		s_d.boot_we = 1'b0;
		s_d.fetch_v = 1'b0;
		s_d.clk_div = !s_q.clk_div; // [RULE_13]
		// Grant only between external accesses
		if (!bus_request_n && !busy && !rq.done && !s_q.req_valid) // [RULE_18]
			s_d.grant = 1'b1;
		else if (bus_request_n)
			s_d.grant = 1'b0;
		unique case (s_q.fsm)
			ST_RESET:
			begin
				s_d.map_hi = memory_map_select; // [RULE_15]
				if (!memory_map_select && bus_request_n) // [RULE_09] [RULE_17]
					s_d.fsm = ST_BOOT_REQ;
				else
				begin
					s_d.fsm = ST_RUN;
					s_d.fetch = FIRST_FETCH; // [RULE_10]
					s_d.fetch_v = 1'b1;
				end
			end
			ST_BOOT_REQ:
			begin
				s_d.req_valid = 1'b1;
				s_d.req_write = 1'b0;
				s_d.req_space = SP_BOOT;
				s_d.req_addr = {s_q.page[0], s_q.boot_idx, s_q.boot_byte}; // [RULE_02]
				s_d.fsm = ST_BOOT_WAIT;
			end
			ST_BOOT_WAIT:
			begin
				if (rq.done)
				begin
					s_d.req_valid = 1'b0;
					if (s_q.boot_byte == 2'h2)
					begin
						s_d.boot_byte = 2'h0;
						s_d.boot_idx = s_q.boot_idx + 11'h1;
						s_d.boot_we = 1'b1;
						if (s_q.boot_idx[8:0] == 9'h1ff)
						begin
							s_d.fsm = ST_RUN;
							s_d.fetch = FIRST_FETCH; // [RULE_10]
							s_d.fetch_v = 1'b1;
						end
						else
							s_d.fsm = ST_BOOT_REQ;
					end
					else
					begin
						s_d.boot_acc = {s_q.boot_acc[7:0], rq.rdata[15:8]};
						s_d.boot_byte = s_q.boot_byte + 2'h1;
						s_d.fsm = ST_BOOT_REQ;
					end
				end
			end
			ST_RUN:
			begin
				if (s_q.force_boot && !s_q.map_hi)
				begin
					s_d.force_boot = 1'b0;
					s_d.boot_idx = 11'h000;
					s_d.fsm = ST_BOOT_REQ;
				end
			end
			ST_ACC_WAIT:
			begin
				if (rq.done)
				begin
					s_d.req_valid = 1'b0;
					s_d.fsm = ST_RUN;
					if (!s_q.req_write)
					begin
						s_d.rdata = rq.rdata[23:8]; // [RULE_06]
						if (s_q.req_space == SP_PROG)
							s_d.px = rq.rdata[7:0]; // [RULE_06]
					end
				end
			end
			default: s_d.fsm = ST_RESET;
		endcase
		// APB register writes
		if (psel && penable && pwrite)
		begin
			unique case (paddr)
				R_CTRL:
				begin
					s_d.pm_wait = pwdata[2:0];
					s_d.dm_wait = pwdata[5:3];
					s_d.boot_wait = pwdata[8:6];
					s_d.page = pwdata[11:9];
					s_d.sport_alt = pwdata[12];
					s_d.flag_out = pwdata[13];
					if (pwdata[14])
						s_d.force_boot = 1'b1;
				end
				R_ACC:
				begin
					if (s_q.fsm == ST_RUN)
					begin
						s_d.req_addr = pwdata[13:0];
						s_d.req_space = pwdata[16] ? SP_DATA : SP_PROG;
						s_d.req_write = pwdata[17];
						s_d.acc_err = !pwdata[16] && is_internal(s_q.map_hi, pwdata[13:0]); // [RULE_16] [RULE_17]
						if (!s_d.acc_err)
						begin
							s_d.req_valid = 1'b1;
							s_d.fsm = ST_ACC_WAIT;
						end
					end
				end
				R_DATA: s_d.wdata = pwdata[15:0];
				R_PX:   s_d.px = pwdata[7:0];
				R_MODE: s_d.mode = pwdata[6:0];
				default: ;
			endcase
		end
		s_d.prdata = 32'h0;
		if (psel && !penable && !pwrite)
		begin
			unique case (paddr)
				R_CTRL: s_d.prdata = {18'h0, s_q.flag_out, s_q.sport_alt, s_q.page, s_q.boot_wait,
					s_q.dm_wait, s_q.pm_wait};
				R_DATA: s_d.prdata = {16'h0, s_q.rdata};
				R_PX:   s_d.prdata = {24'h0, s_q.px};
				R_STAT: s_d.prdata = {18'h0, s_q.stack_ptr, s_q.imask, s_q.acc_err, s_q.grant,
					s_q.map_hi, s_q.fsm, busy};
				R_MODE: s_d.prdata = {25'h0, s_q.mode};
				default: s_d.prdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_q <= '0;
			s_q.fsm <= ST_RESET;
			s_q.pm_wait <= PM_WAIT_RST; // [RULE_07]
			s_q.dm_wait <= PM_WAIT_RST;
			s_q.boot_wait <= BOOT_WAIT_RST;
			s_q.page <= PAGE_RST;
			s_q.mode <= MODE_RST; // [RULE_08]
			s_q.imask <= IMASK_RST; // [RULE_08]
			s_q.stack_ptr <= STACK_EMPTY; // [RULE_08]
		end
		else
			s_q <= s_d;
	end

	assign prdata                 = s_q.prdata;
	assign pready                 = 1'b1;
	assign pslverr                = psel && penable && !(paddr inside {R_CTRL, R_ACC, R_DATA, R_PX, R_STAT, R_MODE});
	assign addr_oe_n              = s_q.grant; // [RULE_18]
	assign ctrl_oe_n              = s_q.grant; // [RULE_18]
	assign bus_grant_n            = !s_q.grant; // [RULE_18]
	assign halted                 = s_q.grant || s_q.fsm != ST_RUN;
	assign output_clock           = s_q.clk_div; // [RULE_13] [RULE_12]
	assign port_one_transmit_data = s_q.sport_alt ? s_q.flag_out : 1'b0; // [RULE_14]
	assign ext_interrupt_zero_n   = s_q.sport_alt ? port_one_receive_frame_sync : 1'b1; // [RULE_14]
	assign ext_interrupt_one_n    = s_q.sport_alt ? port_one_transmit_frame_sync : 1'b1; // [RULE_14]
	assign flag_input_pin         = s_q.sport_alt ? port_one_receive_data : 1'b0; // [RULE_14]
	assign fetch_addr             = s_q.fetch;
	assign fetch_valid            = s_q.fetch_v;
endmodule
`default_nettype wire

//--- emsi_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module emsi_mem_model (
	// Clock
	input  wire logic        pclk,
	// Memory pins
	input  wire logic [13:0] addr_out,
	input  wire logic [23:0] data_out,
	input  wire logic        read_strobe_n,
	input  wire logic        write_strobe_n,
	output logic [23:0]      data_in
);
	logic [23:0] mem [0:16383];
	logic [23:0] last = 24'h000000;
	initial
	begin
		for (int i = 0; i < 16384; i++)
			mem[i] = 24'(i) ^ 24'ha5a5a5;
	end
	// Stores on every write-strobed cycle, the last one wins
	always @(posedge pclk)
	begin
		if (!write_strobe_n)
			mem[addr_out] <= data_out;
		if (!read_strobe_n)
			last <= mem[addr_out];
	end
	// Released bus shows the inverse of the last value
	assign data_in = !read_strobe_n ? mem[addr_out] : ~last;
endmodule
`default_nettype wire

//--- ext_memory_system_interface_sva.sv
`timescale 1ns/100ps
`default_nettype none
module ext_memory_system_interface_sva (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// Pins
	input wire logic [13:0] addr_out,
	input wire logic [23:0] data_out,
	input wire logic        addr_oe_n,
	input wire logic        data_oe_n,
	input wire logic        ctrl_oe_n,
	input wire logic        program_space_select_n,
	input wire logic        data_space_select_n,
	input wire logic        boot_space_select_n,
	input wire logic        read_strobe_n,
	input wire logic        write_strobe_n,
	input wire logic        bus_request_n,
	input wire logic        bus_grant_n,
	input wire logic        output_clock,
	input wire logic        fetch_valid,
	input wire logic [13:0] fetch_addr
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic idle;
	assign idle = program_space_select_n & data_space_select_n & boot_space_select_n;
	logic [2:0] sel_low;
	assign sel_low = {!program_space_select_n, !data_space_select_n, !boot_space_select_n};
	sequence s_wr_on;
		!write_strobe_n ##1 !write_strobe_n;
	endsequence
	a_one_select: assert property ($onehot0(sel_low))
		else $error("two selects low");
	a_strobe_idle: assert property (idle |-> read_strobe_n && write_strobe_n)
		else $error("strobe without select");
	a_strobe_excl: assert property (!(!read_strobe_n && !write_strobe_n))
		else $error("both strobes low");
	a_write_drives: assert property (!write_strobe_n |-> !data_oe_n && boot_space_select_n)
		else $error("write without data drive");
	a_write_hold: assert property (s_wr_on |-> $stable(addr_out) && $stable(data_out))
		else $error("bus moved in write");
	a_read_bound: assert property ($fell(read_strobe_n) |-> ##[1:8] read_strobe_n)
		else $error("read strobe too long");
	a_grant_soon: assert property (!bus_request_n |-> ##[1:10] !bus_grant_n)
		else $error("grant late");
	a_grant_float: assert property (!bus_grant_n |-> addr_oe_n && ctrl_oe_n)
		else $error("driving while granted");
	a_grant_drop: assert property ($rose(bus_request_n) |=> bus_grant_n)
		else $error("grant held");
	a_clock_toggle: assert property (1'b1 |=> output_clock != $past(output_clock))
		else $error("clock out stuck");
	a_fetch_zero: assert property (fetch_valid |-> fetch_addr == 14'h0000 && boot_space_select_n)
		else $error("bad first fetch");
endmodule
bind ext_memory_system_interface ext_memory_system_interface_sva ext_memory_system_interface_sva_i (.*);
`default_nettype wire

//--- ext_memory_system_interface_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module ext_memory_system_interface_tb_top;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [13:0] addr_out, fetch_addr, fv_addr;
	logic [23:0] data_out, data_in;
	logic        addr_oe_n, data_oe_n, program_space_select_n, data_space_select_n, boot_space_select_n;
	logic        read_strobe_n, write_strobe_n, ctrl_oe_n, bus_grant_n, output_clock, halted, fetch_valid;
	logic        bus_request_n = 1, memory_map_select = 0, port_one_receive_frame_sync = 1;
	logic        port_one_transmit_frame_sync = 1, port_one_receive_data = 0, boot_seen = 0, fv = 0;
	logic        port_one_transmit_data, ext_interrupt_zero_n, ext_interrupt_one_n, flag_input_pin;
	int          n_fail = 0, check_count = 0, sc = 0, i;
	ext_memory_system_interface ext_memory_system_interface_i (.*);
	emsi_mem_model emsi_mem_model_i (.*);
	always #4 pclk = ~pclk;
	always @(posedge pclk)
	begin
		if (!boot_space_select_n)
			boot_seen <= 1;
		if ((!read_strobe_n || !write_strobe_n) && !program_space_select_n)
			sc <= sc + 1;
		if (fetch_valid === 1'b1)
		begin
			fv <= 1;
			fv_addr <= fetch_addr;
		end
	end
	task automatic end_of_test;
		$display("checks %0d fails %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task automatic acc(input logic [13:0] a, input logic ds, input logic w);
		apb(1, 12'h004, {14'h0, w, ds, 2'h0, a});
		repeat (2) @(posedge pclk);
		for (i = 0; i < 100; i++)
		begin
			apb(0, 12'h010, 0);
			if (rd[0] === 1'b0)
				break;
		end
	endtask
	task automatic rst(input logic m, input logic b);
		presetn <= 0;
		memory_map_select <= m;
		bus_request_n <= b;
		repeat (5) @(posedge pclk);
		boot_seen = 0;
		fv = 0;
		presetn <= 1;
		@(posedge pclk);
	endtask
	task automatic wait_fetch;
		for (i = 0; i < 20000 && fv !== 1'b1; i++)
			@(posedge pclk);
		chk(fv, 1);
		chk(fv_addr, 0);
	endtask
	initial
	begin
		#400000;
		n_fail++;
		end_of_test;
	end
	initial
	begin
		rst(0, 1);
		emsi_mem_model_i.mem[0] = 24'h001100;
		emsi_mem_model_i.mem[1] = 24'h002200;
		emsi_mem_model_i.mem[2] = 24'h003300;
		wait_fetch();
		chk(boot_seen, 1);
		chk(ext_memory_system_interface_i.u_ram.mem[0], 24'h112233);
		apb(0, 12'h000, 0);
		chk(rd, 32'h0ff);
		apb(0, 12'h014, 0);
		chk(rd, 0);
		apb(0, 12'h010, 0);
		chk(rd[13:4], 0);
		apb(0, 12'h020, 0);
		chk({rd[30:0], err}, 1);
		apb(1, 12'h008, 32'h1234);
		apb(1, 12'h00c, 32'hab);
		acc(14'h0100, 0, 1);
		apb(0, 12'h010, 0);
		chk(rd[6], 1);
		acc(14'h0800, 0, 1);
		chk(emsi_mem_model_i.mem[14'h0800], 24'h1234ab);
		fv = 0;
		boot_seen = 0;
		apb(1, 12'h000, 32'h40ff);
		wait_fetch();
		chk(boot_seen, 1);
		$display("map low done");
		rst(0, 0);
		repeat (40) @(posedge pclk);
		chk(boot_seen, 0);
		chk({bus_grant_n, addr_oe_n, ctrl_oe_n, halted}, 4'b0111);
		rst(1, 1);
		wait_fetch();
		chk(boot_seen, 0);
		chk(halted, 0);
		apb(0, 12'h010, 0);
		chk(rd[4], 1);
		apb(1, 12'h008, 32'h5a5a);
		apb(1, 12'h00c, 32'hc3);
		for (int w = 0; w < 8; w++)
		begin
			apb(1, 12'h000, 32'(w));
			sc = 0;
			acc(14'(w), 0, 1);
			chk(sc, 32'(w + 1));
			chk(emsi_mem_model_i.mem[w], 24'h5a5ac3);
		end
		emsi_mem_model_i.mem[14'h0200] = 24'hc3d2e1;
		acc(14'h0200, 0, 0);
		apb(0, 12'h008, 0);
		chk(rd, 32'hc3d2);
		apb(0, 12'h00c, 0);
		chk(rd, 32'he1);
		acc(14'h3800, 0, 1);
		apb(0, 12'h010, 0);
		chk(rd[6], 1);
		apb(1, 12'h008, 32'hbeef);
		acc(14'h0300, 1, 1);
		chk(emsi_mem_model_i.mem[14'h0300][23:8], 16'hbeef);
		emsi_mem_model_i.mem[14'h0301] = 24'h13579b;
		acc(14'h0301, 1, 0);
		apb(0, 12'h008, 0);
		chk(rd, 32'h1357);
		$display("map high done");
		apb(1, 12'h000, 32'h3000);
		port_one_receive_frame_sync <= 0;
		port_one_receive_data <= 1;
		repeat (2) @(posedge pclk);
		chk({ext_interrupt_zero_n, ext_interrupt_one_n, flag_input_pin, port_one_transmit_data}, 4'b0111);
		apb(1, 12'h000, 0);
		repeat (2) @(posedge pclk);
		chk({ext_interrupt_zero_n, ext_interrupt_one_n, flag_input_pin, port_one_transmit_data}, 4'b1100);
		bus_request_n <= 0;
		repeat (3) @(posedge pclk);
		chk({bus_grant_n, addr_oe_n, ctrl_oe_n, halted}, 4'b0111);
		bus_request_n <= 1;
		repeat (3) @(posedge pclk);
		chk(bus_grant_n, 1);
		$display("pins done");
		end_of_test;
	end
endmodule
`default_nettype wire
